// File: logic/rhci_interp.sv
// Command framing, decoding, replies, download mode and tag buffering
`timescale 1ns/1ns
module rhci_interp #(
	parameter int UNIQ_DEPTH = 4,
	parameter logic [31:0] SW_VERSION = "1.00"
) (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic rx_valid_in,
	input wire logic [7:0] rx_data_in,
	output logic rx_ready_out,
	output logic tx_valid_out,
	output logic [7:0] tx_data_out,
	input wire logic tx_ready_in,
	input wire logic echo_en_in,
	input wire logic ecp_mode_in,
	input wire logic boot_ok_in,
	input wire logic flash_ok_in,
	input wire logic [23:0] serial_in,
	input wire logic power_fail_event_in,
	input wire logic erase_done_in,
	input wire logic erase_ok_in,
	input wire logic tag_valid_in,
	input wire logic tag_ack_in,
	output logic command_mode_out,
	output logic download_mode_out,
	output logic fixed_link_out,
	output logic echo_active_out,
	output logic serial_set_out,
	output logic power_fail_out,
	output logic nv_commit_out,
	output logic reader_reset_out,
	output logic erase_start_out,
	output logic prog_write_out,
	output logic [15:0] prog_word_out,
	output logic cmd_valid_out,
	output rhci_pkg::rhci_cmd_s cmd_out,
	output logic tag_enable_out,
	output logic [3:0] tag_count_out,
	output logic tag_drop_out
);
	typedef struct packed {
		rhci_pkg::rhci_st_e st;
		rhci_pkg::rhci_reply_e reply;
		logic [4:0] idx;
		logic [3:0] len;
		logic [rhci_pkg::CMD_MAX-1:0][7:0] cbuf;
		logic in_frame;
		logic ovf;
		logic cmd_mode;
		logic dl_mode;
		logic erased;
		logic pwr_flag;
		logic failed;
		logic [rhci_pkg::FIFO_DEPTH-1:0][7:0] fent;
		logic [1:0] fcnt;
		logic [3:0] tag_cnt;
		logic tag_drop;
		logic nv_commit;
		logic rst_pulse;
		logic erase_start;
		logic prog_wr;
		logic [15:0] prog_word;
		logic cmd_v;
		rhci_pkg::rhci_cmd_s cmd;
	} rhci_state_s;

	rhci_state_s q;
	rhci_state_s d;

	// Bit 4 marks a legal upper-case hex digit
	function automatic logic [4:0] hexv(input logic [7:0] c);
		logic [4:0] r;
		r = 5'h00;
		if (c >= 8'h30 && c <= 8'h39)
		begin
			r = {1'b1, c[3:0]};
		end
		else if (c >= 8'h41 && c <= 8'h46)
		begin
			r = {1'b1, 4'(c[3:0] + 4'h9)};
		end
		return r;
	endfunction

	function automatic logic is2(input logic [7:0] a, input logic [7:0] b,
		input logic [7:0] x, input logic [7:0] y);
		return a == x && b == y;
	endfunction

	logic [8*rhci_pkg::MSG_BYTES-1:0] msg;
	logic [4:0] mlen;
	logic [47:0] sn_ascii;
	logic [3:0] tag_limit;
	logic push_v;
	logic [7:0] push_b;
	logic pop;
	logic echo_on;
	logic [7:0] c0;
	logic [7:0] c1;
	logic [7:0] c2;
	logic [7:0] c3;
	logic [4:0] h0;
	logic [4:0] h1;
	logic [4:0] h2;
	logic [4:0] h3;
	logic [4:0] h4;
	logic [4:0] h5;
	logic [4:0] h6;

	always_comb
	begin
		for (int i = 0; i < 6; i++)
		begin
			sn_ascii[8*i +: 8] = {4'h3, serial_in[4*i +: 4]};
		end
		msg = '0;
		mlen = 5'(rhci_pkg::LEN_ERROR);
		case (q.reply)
			rhci_pkg::RP_DONE:
			begin
				msg = 256'({"#Done", rhci_pkg::CH_CR, rhci_pkg::CH_LF});
				mlen = 5'(rhci_pkg::LEN_DONE);
			end
			rhci_pkg::RP_PWR:
			begin
				msg = 256'({rhci_pkg::CH_SOM, rhci_pkg::POWER_LOSS_REPLY_TAG, 8'h20,
					7'h18, q.pwr_flag, rhci_pkg::CH_CR, rhci_pkg::CH_LF});
				mlen = 5'(rhci_pkg::LEN_PWR);
			end
			rhci_pkg::RP_SIGNON:
			begin
				msg = 256'({"#Reader Ver ", SW_VERSION, " SN", sn_ascii,
					rhci_pkg::CH_CR, rhci_pkg::CH_LF});
				mlen = rhci_pkg::LEN_SIGNON;
			end
			rhci_pkg::RP_BOOT:
			begin
				msg = 256'({"#Reader Ver 0.00x", rhci_pkg::CH_CR, rhci_pkg::CH_LF});
				mlen = rhci_pkg::LEN_BOOT;
			end
			rhci_pkg::RP_FAIL:
			begin
				msg = 256'({"#Boot Fail", rhci_pkg::CH_CR, rhci_pkg::CH_LF});
				mlen = 5'(rhci_pkg::LEN_FAIL);
			end
			default:
			begin
				msg = 256'({"#Error", rhci_pkg::CH_CR, rhci_pkg::CH_LF});
				mlen = 5'(rhci_pkg::LEN_ERROR);
			end
		endcase
	end

	always_comb
	begin
		d = q;
		d.nv_commit = 1'b0;
		d.rst_pulse = 1'b0;
		d.erase_start = 1'b0;
		d.prog_wr = 1'b0;
		d.cmd_v = 1'b0;
		d.tag_drop = 1'b0;
		push_v = 1'b0;
		push_b = q.fent[0];
		c0 = q.cbuf[0];
		c1 = q.cbuf[1];
		c2 = q.cbuf[2];
		c3 = q.cbuf[3];
		h0 = hexv(c0);
		h1 = hexv(c1);
		h2 = hexv(c2);
		h3 = hexv(c3);
		h4 = hexv(q.cbuf[4]);
		h5 = hexv(q.cbuf[5]);
		h6 = hexv(q.cbuf[6]);
		echo_on = echo_en_in && !q.dl_mode;
		rx_ready_out = q.st == rhci_pkg::ST_IDLE && (!echo_on || q.fcnt < 2'd2);

		case (q.st)
			rhci_pkg::ST_START:
			begin
				d.idx = 5'h00;
				d.erased = 1'b0;
				d.cmd_mode = 1'b0;
				d.st = rhci_pkg::ST_SEND;
				if (!boot_ok_in)
				begin
					d.reply = rhci_pkg::RP_FAIL;
					d.failed = 1'b1;
				end
				else if (flash_ok_in)
				begin
					d.reply = rhci_pkg::RP_SIGNON;
					d.dl_mode = 1'b0;
				end
				else
				begin
					d.reply = rhci_pkg::RP_BOOT;
					d.dl_mode = 1'b1;
				end
			end
			rhci_pkg::ST_IDLE:
			begin
				if (rx_valid_in && rx_ready_out)
				begin
					if (echo_on)
					begin
						push_v = 1'b1;
						push_b = rx_data_in;
					end
					if (rx_data_in == rhci_pkg::CH_SOM)
					begin
						d.in_frame = 1'b1;
						d.len = 4'h0;
						d.ovf = 1'b0;
						d.cbuf = '0;
					end
					else if (q.in_frame && rx_data_in == rhci_pkg::CH_CR)
					begin
						d.in_frame = 1'b0;
						d.st = rhci_pkg::ST_DECODE;
					end
					else if (q.in_frame)
					begin
						if (q.len < 4'(rhci_pkg::CMD_MAX))
						begin
							d.cbuf[q.len[2:0]] = rx_data_in;
							d.len = q.len + 4'h1;
						end
						else
						begin
							d.ovf = 1'b1;
						end
					end
				end
			end
			rhci_pkg::ST_DECODE:
			begin
				d.idx = 5'h00;
				d.st = rhci_pkg::ST_SEND;
				d.reply = rhci_pkg::RP_ERROR;
				if (q.ovf || q.len < 4'h2)
				begin
					d.reply = rhci_pkg::RP_ERROR;
				end
				else if (q.dl_mode)
				begin
					if (c0 != rhci_pkg::CH_DL)
					begin
						d.reply = rhci_pkg::RP_ERROR;
					end
					else if (c1 == rhci_pkg::CH_ERASE && q.len == 4'h2)
					begin
						d.erase_start = 1'b1;
						d.erased = 1'b0;
						d.st = rhci_pkg::ST_ERASE;
					end
					else if (c1 == rhci_pkg::CH_WRITE && q.len == 4'h6
						&& h2[4] && h3[4] && h4[4] && h5[4])
					begin
						if (q.erased)
						begin
							d.prog_wr = 1'b1;
							d.prog_word = {h2[3:0], h3[3:0], h4[3:0], h5[3:0]};
							d.reply = rhci_pkg::RP_DONE;
						end
						else
						begin
							d.reply = rhci_pkg::RP_ERROR;
						end
					end
					else if (c1 == rhci_pkg::CH_EXIT && q.len == 4'h2)
					begin
						d.st = rhci_pkg::ST_START;
					end
				end
				else if (q.len == 4'h2 && is2(c0, c1, "0", "0"))
				begin
					d.cmd_mode = 1'b0;
					d.nv_commit = 1'b1;
					d.reply = rhci_pkg::RP_DONE;
				end
				else if (q.len == 4'h2 && is2(c0, c1, "0", "1"))
				begin
					d.cmd_mode = 1'b1;
					d.reply = rhci_pkg::RP_DONE;
				end
				else if (!q.cmd_mode)
				begin
					d.reply = rhci_pkg::RP_ERROR;
				end
				else if (q.len == 4'h3 && is2(c0, c1, "5", "2") && c2 == "0")
				begin
					d.reply = rhci_pkg::RP_PWR;
				end
				else if (q.len == 4'h3 && is2(c0, c1, "5", "0") && c2 == "5")
				begin
					d.reply = rhci_pkg::RP_SIGNON;
				end
				else if (q.len == 4'h2 && is2(c0, c1, "6", "3"))
				begin
					d.rst_pulse = 1'b1;
					d.reply = rhci_pkg::RP_DONE;
				end
				else if (q.len == 4'h2 && is2(c0, c1, "6", "5"))
				begin
					d.reply = rhci_pkg::RP_DONE;
				end
				else if (q.len == 4'h2 && is2(c0, c1, "6", rhci_pkg::CH_ENTER_DL))
				begin
					d.dl_mode = 1'b1;
					d.erased = 1'b0;
					d.reply = rhci_pkg::RP_DONE;
				end
				else if (q.len >= 4'h4 && h0[4] && h1[4] && h2[4])
				begin
					d.cmd_v = 1'b1;
					d.cmd.group = h0[3:0];
					d.cmd.subgroup = h1[3:0];
					d.cmd.digit = h2[3:0];
					d.cmd.text = {c3, q.cbuf[4], q.cbuf[5], q.cbuf[6], q.cbuf[7]};
					d.cmd.value_ok = 1'b0;
					d.cmd.value = 16'h0000;
					if (q.len == 4'h4 && h3[4])
					begin
						d.cmd.value = {12'h000, h3[3:0]};
						d.cmd.value_ok = 1'b1;
					end
					else if (q.len == 4'h7 && h3[4] && h4[4] && h5[4] && h6[4])
					begin
						d.cmd.value = {h3[3:0], h4[3:0], h5[3:0], h6[3:0]};
						d.cmd.value_ok = 1'b1;
					end
					d.reply = rhci_pkg::RP_DONE;
				end
			end
			rhci_pkg::ST_ERASE:
			begin
				// Erase takes seconds; the host waits for the reply
				if (erase_done_in)
				begin
					d.erased = erase_ok_in;
					d.reply = erase_ok_in ? rhci_pkg::RP_DONE : rhci_pkg::RP_ERROR;
					d.idx = 5'h00;
					d.st = rhci_pkg::ST_SEND;
				end
			end
			rhci_pkg::ST_SEND:
			begin
				if (q.fcnt < 2'd2)
				begin
					push_v = 1'b1;
					push_b = msg[8*(5'(mlen - 5'h1 - q.idx)) +: 8];
					d.idx = q.idx + 5'h1;
					if (q.idx == mlen - 5'h1)
					begin
						d.st = q.failed ? rhci_pkg::ST_HALT : rhci_pkg::ST_IDLE;
					end
				end
			end
			rhci_pkg::ST_HALT:
			begin
				d.st = rhci_pkg::ST_HALT;
			end
			default:
			begin
				d.st = rhci_pkg::ST_START;
			end
		endcase

		// Flag clears lose to a power-fail event in the same cycle
		if (d.rst_pulse || (q.st == rhci_pkg::ST_DECODE && d.reply == rhci_pkg::RP_DONE
			&& !q.dl_mode && q.len == 4'h2 && is2(c0, c1, "6", "5")))
		begin
			d.pwr_flag = 1'b0;
		end
		if (power_fail_event_in)
		begin
			d.pwr_flag = 1'b1;
		end

		// Two-entry transmit buffer, head at entry 0
		pop = q.fcnt != 2'd0 && tx_ready_in;
		if (pop)
		begin
			d.fent[0] = q.fent[1];
		end
		if (push_v)
		begin
			d.fent[pop ? 1'(q.fcnt - 2'd1) : 1'(q.fcnt)] = push_b;
		end
		d.fcnt = q.fcnt + 2'(push_v) - 2'(pop);

		// Tag occupancy; entries freed as the host takes them
		tag_limit = ecp_mode_in && !q.dl_mode ? 4'(1 + rhci_pkg::ECP_EXTRA_TAGS)
			: 4'(UNIQ_DEPTH);
		if (tag_ack_in && q.tag_cnt != 4'h0)
		begin
			d.tag_cnt = q.tag_cnt - 4'h1;
		end
		if (tag_valid_in && !q.dl_mode)
		begin
			if (d.tag_cnt < tag_limit)
			begin
				d.tag_cnt = d.tag_cnt + 4'h1;
			end
			else
			begin
				d.tag_drop = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			q <= '0;
		end
		else
		begin
			q <= d;
		end
	end

	assign tx_valid_out = q.fcnt != 2'd0;
	assign tx_data_out = q.fent[0];
	assign command_mode_out = q.cmd_mode;
	assign download_mode_out = q.dl_mode;
	assign fixed_link_out = q.dl_mode;
	assign echo_active_out = echo_en_in && !q.dl_mode;
	assign serial_set_out = serial_in != 24'h000000;
	assign power_fail_out = q.pwr_flag;
	assign nv_commit_out = q.nv_commit;
	assign reader_reset_out = q.rst_pulse;
	assign erase_start_out = q.erase_start;
	assign prog_write_out = q.prog_wr;
	assign prog_word_out = q.prog_word;
	assign cmd_valid_out = q.cmd_v;
	assign cmd_out = q.cmd;
	assign tag_enable_out = !q.dl_mode;
	assign tag_count_out = q.tag_cnt;
	assign tag_drop_out = q.tag_drop;
endmodule

// File: logic/rhci_pkg.sv
// Constants, types and reply lengths for the reader host command interpreter
// How it works
// - Commands and replies open with hash
// - Carriage return ends an incoming command
// - Every reply ends with CR then LF
// - Variable digits are hex 0-9, A-F
// - Under two characters after hash: error
// - Digits read as group, subgroup, command, setting
// - Setting: one hex, four hex or text
// - Done when handled, otherwise error reply
// - Queries answer identifier, space, value literally
// - Command-mode command enters command mode, done
// - Data-mode command commits parameters, enters data mode
// - Power-fail flag kept and reported 0/1
// - Reader reset or flag reset clears flag
// - Download mode suspends all tag processing; the code still lets tag_ack_in lower the tag count there
// - Program data refused until erase succeeded
// - Leaving download reruns startup, boot sign-on
// - Download: fixed link settings, no echo
// - Startup sends sign-on or boot failure
// - Serial number all zeros means unset
// - Flash checksum failure enters download mode
// - Error-correcting protocol holds three extra tags
// - Basic protocol drops tags when buffer full
package rhci_pkg;
	localparam logic [7:0] CH_SOM = 8'h23;
	localparam logic [7:0] CH_CR = 8'h0d;
	localparam logic [7:0] CH_LF = 8'h0a;
	localparam int CMD_MAX = 8;
	localparam int MSG_BYTES = 32;
	localparam int FIFO_DEPTH = 2;
	localparam int ECP_EXTRA_TAGS = 3;
	localparam logic [3:0] LEN_DONE = 4'h7;
	localparam logic [3:0] LEN_ERROR = 4'h8;
	localparam logic [3:0] LEN_PWR = 4'h9;
	localparam logic [4:0] LEN_SIGNON = 5'h1b;
	localparam logic [4:0] LEN_BOOT = 5'h13;
	localparam logic [3:0] LEN_FAIL = 4'hc;
	// Download-mode and download-entry command letters
	localparam logic [7:0] CH_DL = 8'h44;
	localparam logic [7:0] CH_ERASE = 8'h45;
	localparam logic [7:0] CH_WRITE = 8'h57;
	localparam logic [7:0] CH_EXIT = 8'h58;
	localparam logic [7:0] CH_ENTER_DL = 8'h46;
	localparam logic [31:0] POWER_LOSS_REPLY_TAG = "PFLG";

	typedef enum logic [2:0] {ST_START, ST_IDLE, ST_DECODE, ST_ERASE, ST_SEND, ST_HALT} rhci_st_e;
	typedef enum logic [2:0] {RP_DONE, RP_ERROR, RP_PWR, RP_SIGNON, RP_BOOT, RP_FAIL} rhci_reply_e;

	typedef struct packed {
		logic [3:0] group;
		logic [3:0] subgroup;
		logic [3:0] digit;
		logic [15:0] value;
		logic value_ok;
		logic [39:0] text;
	} rhci_cmd_s;
endpackage

// File: verif/rhci_asserts.sv
// Port checker for the reader host command interpreter
`timescale 1ns/1ns
module rhci_asserts #(
	parameter int UNIQ_DEPTH = 4
) (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic rx_valid_in,
	input wire logic [7:0] rx_data_in,
	input wire logic rx_ready_out,
	input wire logic tx_valid_out,
	input wire logic [7:0] tx_data_out,
	input wire logic tx_ready_in,
	input wire logic ecp_mode_in,
	input wire logic power_fail_event_in,
	input wire logic erase_done_in,
	input wire logic erase_ok_in,
	input wire logic download_mode_out,
	input wire logic fixed_link_out,
	input wire logic echo_active_out,
	input wire logic command_mode_out,
	input wire logic nv_commit_out,
	input wire logic reader_reset_out,
	input wire logic cmd_valid_out,
	input wire logic power_fail_out,
	input wire logic prog_write_out,
	input wire logic tag_enable_out,
	input wire logic [3:0] tag_count_out,
	input wire logic tag_drop_out
);
	localparam int ECP_DEPTH = 1 + rhci_pkg::ECP_EXTRA_TAGS;
	logic erased_q;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);
	// Leaving download forgets the erase, so a new load needs a new erase
	always_ff @(posedge clk_in or posedge reset_in)
		if (reset_in)
			erased_q <= 1'b0;
		else
			erased_q <= download_mode_out && (erased_q || (erase_done_in && erase_ok_in));
	sequence s_cr_taken;
		rx_valid_in && rx_ready_out && rx_data_in == rhci_pkg::CH_CR;
	endsequence
	sequence s_tx_stall;
		tx_valid_out && !tx_ready_in;
	endsequence
	a_cr_starts_decode: assert property (s_cr_taken |=> (!rx_ready_out) [*2])
		else $error("command bytes taken during decode");
	a_tx_word_holds: assert property (s_tx_stall |=> tx_valid_out && $stable(tx_data_out))
		else $error("reply byte lost under stall");
	a_tags_suspended: assert property (download_mode_out |-> !tag_enable_out)
		else $error("tag processing active in download");
	a_link_fixed: assert property (fixed_link_out == download_mode_out)
		else $error("fixed link setting differs from download mode");
	a_download_no_echo: assert property (download_mode_out |-> !echo_active_out)
		else $error("echo active in download");
	a_drop_at_limit: assert property (tag_drop_out |->
		tag_count_out == (ecp_mode_in ? ECP_DEPTH : UNIQ_DEPTH))
		else $error("tag dropped below buffer limit");
	a_write_after_erase: assert property (prog_write_out |-> erased_q)
		else $error("program word accepted without erase");
	a_power_flag_set: assert property (power_fail_event_in |=> power_fail_out)
		else $error("power fail flag not set");
	a_commit_to_data: assert property (nv_commit_out |-> !command_mode_out)
		else $error("commit pulse while still in command mode");
	a_reset_clears_flag: assert property (reader_reset_out |->
		!power_fail_out || $past(power_fail_event_in))
		else $error("reader reset left power fail flag set");
	a_fields_need_mode: assert property (cmd_valid_out |-> command_mode_out)
		else $error("command fields issued outside command mode");
endmodule
bind rhci_interp rhci_asserts #(.UNIQ_DEPTH(UNIQ_DEPTH)) i_chk (.clk_in(clk_in),
	.reset_in(reset_in), .rx_valid_in(rx_valid_in), .rx_data_in(rx_data_in),
	.rx_ready_out(rx_ready_out), .tx_valid_out(tx_valid_out), .tx_data_out(tx_data_out),
	.tx_ready_in(tx_ready_in), .ecp_mode_in(ecp_mode_in),
	.power_fail_event_in(power_fail_event_in), .erase_done_in(erase_done_in),
	.erase_ok_in(erase_ok_in), .download_mode_out(download_mode_out),
	.fixed_link_out(fixed_link_out), .echo_active_out(echo_active_out),
	.command_mode_out(command_mode_out), .nv_commit_out(nv_commit_out),
	.reader_reset_out(reader_reset_out), .cmd_valid_out(cmd_valid_out),
	.power_fail_out(power_fail_out), .prog_write_out(prog_write_out),
	.tag_enable_out(tag_enable_out), .tag_count_out(tag_count_out),
	.tag_drop_out(tag_drop_out));

// File: verif/rhci_host.sv
// Host computer model on the serial byte side of the interpreter
`timescale 1ns/1ns
module rhci_host (
	input wire logic clk_in,
	input wire logic reset_in,
	output logic rx_valid_out,
	output logic [7:0] rx_data_out,
	input wire logic rx_ready_in,
	input wire logic tx_valid_in,
	input wire logic [7:0] tx_data_in,
	output logic tx_ready_out
);
	logic [7:0] sendq[$];
	logic [7:0] got[$];
	logic slow = 1'b0;
	logic took = 1'b0;
	logic [1:0] phase = 2'h0;
	initial
	begin
		rx_valid_out = 1'b0;
		rx_data_out = 8'h00;
		tx_ready_out = 1'b1;
	end
	// Falling edge sees the same settled values as the next rising edge
	always @(negedge clk_in)
	begin
		took = rx_valid_out && rx_ready_in;
		if (tx_valid_in && tx_ready_out)
			got.push_back(tx_data_in);
	end
	always @(posedge clk_in)
	begin
		#1;
		if (took)
			void'(sendq.pop_front());
		took = 1'b0;
		phase = phase + 2'h1;
		// Frame bytes held until taken; idle line toggles so no stale byte reads well
		rx_valid_out = !reset_in && sendq.size() != 0;
		rx_data_out = rx_valid_out ? sendq[0] : ~rx_data_out;
		tx_ready_out = !slow || phase == 2'h0;
	end
endmodule

// File: verif/rhci_interp_tb_top.sv
// Self-checking bench for the reader host command interpreter
`timescale 1ns/1ns
module rhci_interp_tb_top;
	localparam string EOL = "\015\012";
	localparam string DONE = {"#Done", EOL};
	localparam string ERR = {"#Error", EOL};
	logic clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic rv, rr, tv, tr, cm, dm, pf, ew, tge, dr;
	logic [7:0] rd, td;
	logic echo = 1'b0, ecp = 1'b0, fok = 1'b1, pfe = 1'b0;
	logic ed = 1'b0, tgv = 1'b0, tga = 1'b0;
	logic bok = 1'b1, eok = 1'b1, ss;
	logic [23:0] sn = 24'h123456;
	logic [15:0] pw;
	logic [3:0] tc;
	rhci_pkg::rhci_cmd_s cmd;
	int fail_count = 0;
	int tests_run = 0;
	rhci_interp #(.UNIQ_DEPTH(2)) i_dut (.clk_in(clk_in), .reset_in(reset_in),
		.rx_valid_in(rv), .rx_data_in(rd), .rx_ready_out(rr), .tx_valid_out(tv),
		.tx_data_out(td), .tx_ready_in(tr), .echo_en_in(echo), .ecp_mode_in(ecp),
		.boot_ok_in(bok), .flash_ok_in(fok), .serial_in(sn),
		.power_fail_event_in(pfe), .erase_done_in(ed), .erase_ok_in(eok),
		.tag_valid_in(tgv), .tag_ack_in(tga), .command_mode_out(cm),
		.download_mode_out(dm), .fixed_link_out(), .echo_active_out(),
		.serial_set_out(ss), .power_fail_out(pf), .nv_commit_out(), .reader_reset_out(),
		.erase_start_out(ew), .prog_write_out(), .prog_word_out(pw), .cmd_valid_out(),
		.cmd_out(cmd), .tag_enable_out(tge), .tag_count_out(tc), .tag_drop_out(dr));
	rhci_host i_host (.clk_in(clk_in), .reset_in(reset_in), .rx_valid_out(rv),
		.rx_data_out(rd), .rx_ready_in(rr), .tx_valid_in(tv), .tx_data_in(td),
		.tx_ready_out(tr));
	initial
		forever #5 clk_in = ~clk_in;
	// Flash side: erase takes a while, then reports done; eok gives the result
	always @(negedge clk_in)
		if (ew)
		begin
			repeat (20) @(posedge clk_in);
			#1 ed = 1'b1;
			@(posedge clk_in);
			#1 ed = 1'b0;
		end
	task automatic report_and_stop();
		if (fail_count == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
		tests_run++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic reply(input string exp);
		int n;
		n = 0;
		while (i_host.got.size() < exp.len() && n < 4000)
		begin
			// Step off the edge so later stimulus never races the design
			@(posedge clk_in);
			#1;
			n++;
		end
		if (n == 4000)
		begin
			fail_count++;
			$display("MISMATCH reply expected %0d bytes seen %0d", exp.len(), i_host.got.size());
			report_and_stop();
		end
		for (int i = 0; i < exp.len(); i++)
			chk("reply byte", exp[i], i_host.got[i]);
		i_host.got.delete();
	endtask
	task automatic send(input string c, input string exp);
		i_host.sendq.push_back(rhci_pkg::CH_SOM);
		for (int i = 0; i < c.len(); i++)
			i_host.sendq.push_back(c[i]);
		i_host.sendq.push_back(rhci_pkg::CH_CR);
		reply(exp);
	endtask
	task automatic pulse(ref logic s, input int k);
		repeat (k)
		begin
			@(posedge clk_in);
			#1 s = 1'b1;
			@(posedge clk_in);
			#1 s = 1'b0;
		end
	endtask
	task automatic restart();
		@(posedge clk_in);
		#1 reset_in = 1'b1;
		repeat (3) @(posedge clk_in);
		#1 reset_in = 1'b0;
	endtask
	task automatic t_cmds();
		send("01", DONE);
		chk("command mode", 1, cm);
		send("5", ERR);
		send("9Z0", ERR);
		send("1005", DONE);
		chk("group fields", 12'h100, {cmd.group, cmd.subgroup, cmd.digit});
		chk("one digit value", 17'h10005, {cmd.value_ok, cmd.value});
		send("3A1BEEF", DONE);
		chk("group fields", 12'h3a1, {cmd.group, cmd.subgroup, cmd.digit});
		chk("four digit value", 17'h1beef, {cmd.value_ok, cmd.value});
		send("100a", DONE);
		chk("text setting", 17'h00000, {cmd.value_ok, cmd.value});
		// Outside download every taken byte comes back ahead of the reply
		echo = 1'b1;
		send("65", {"#65\015", DONE});
		echo = 1'b0;
	endtask
	task automatic t_power();
		pulse(pfe, 1);
		send("520", {"#PFLG 1", EOL});
		send("65", DONE);
		send("520", {"#PFLG 0", EOL});
		pulse(pfe, 1);
		send("63", DONE);
		chk("power flag", 0, pf);
	endtask
	task automatic t_tags();
		pulse(tgv, 3);
		chk("basic tags", 2, tc);
		pulse(tga, 2);
		ecp = 1'b1;
		pulse(tgv, 5);
		chk("ecp tags", 4, tc);
		pulse(tga, 4);
		ecp = 1'b0;
		chk("tags drained", 0, tc);
	endtask
	task automatic t_download();
		send("6F", DONE);
		chk("download", 1, dm);
		chk("tag enable", 0, tge);
		pulse(tgv, 1);
		chk("download tags", 0, tc);
		echo = 1'b1;
		i_host.slow = 1'b1;
		send("DW1234", ERR);
		eok = 1'b0;
		send("DE", ERR);
		send("DW1234", ERR);
		eok = 1'b1;
		send("DE", DONE);
		send("DW1234", DONE);
		chk("program word", 16'h1234, pw);
		fok = 1'b0;
		send("DX", {"#Reader Ver 0.00x", EOL});
		chk("boot download", 1, dm);
		fok = 1'b1;
		echo = 1'b0;
		send("DX", {"#Reader Ver 1.00 SN123456", EOL});
		i_host.slow = 1'b0;
		chk("data mode", 0, dm | cm);
	endtask
	task automatic t_restart();
		sn = 24'h000000;
		restart();
		reply({"#Reader Ver 1.00 SN000000", EOL});
		chk("serial set", 0, ss);
		bok = 1'b0;
		restart();
		reply({"#Boot Fail", EOL});
		// A halted interpreter must neither take nor answer bytes
		i_host.sendq.push_back(rhci_pkg::CH_SOM);
		repeat (20) @(posedge clk_in);
		#1;
		chk("halted ready", 0, rr);
		chk("halted reply", 0, i_host.got.size());
	endtask
	initial
	begin
		repeat (12) @(posedge clk_in);
		#1 reset_in = 1'b0;
		reply({"#Reader Ver 1.00 SN123456", EOL});
		chk("serial set", 1, ss);
		t_cmds();
		t_power();
		t_tags();
		send("00", DONE);
		chk("command mode off", 0, cm);
		send("520", ERR);
		send("01", DONE);
		t_download();
		t_restart();
		report_and_stop();
	end
endmodule
